// ==== lapic_timer_ext_map.vh ====
// register map, field positions and reset values for the
// local interrupt timer and extended control block
// assumes word-aligned byte addresses on a 32-bit bus
`ifndef LAPIC_TIMER_EXT_MAP_VH
`define LAPIC_TIMER_EXT_MAP_VH

// byte offsets
`define OFS_TIMER_ENTRY 12'h320
`define OFS_ERROR_ENTRY 12'h370
`define OFS_INIT_COUNT 12'h380
`define OFS_CUR_COUNT 12'h390
`define OFS_DIV_CONFIG 12'h3E0
`define OFS_FEATURE_CAPS 12'h400
`define OFS_EXT_CONTROL 12'h410
`define OFS_SPEC_EOI 12'h420
`define OFS_ENABLE_BASE 12'h480
`define OFS_ENABLE_LAST 12'h4F0

// vector table entry fields
`define BIT_MODE 17
`define BIT_MASK 16
`define BIT_PENDING 12
`define KIND_HI 10
`define KIND_LO 8
`define VEC_HI 7
`define VEC_LO 0

// divide configuration fields
`define BIT_DIV_HI 3
`define DIV_LO_HI 1

// extended control fields
`define BIT_WIDE_ID 2
`define BIT_SEOI_EN 1
`define BIT_IER_WR_EN 0

// capability word fields
`define CAP_COUNT_LO 16
`define CAP_EXTRA_ENTRIES 8'h04
`define BIT_CAP_WIDE_ID 2
`define BIT_CAP_SEOI 1
`define BIT_CAP_IER 0

// reset values
`define RST_ENTRY 32'h0001_0000
`define RST_ZERO 32'h0000_0000
`define RST_ENABLE 32'hFFFF_FFFF

// broadcast patterns
`define BCAST_WIDE 8'hFF
`define BCAST_NARROW 4'hF

`endif

// ==== local_interrupt_timer_ext_ctrl.v ====
// local interrupt controller slice: error and timer vector
// table entries, timer counter with divider, capability word,
// extended control, specific end-of-interrupt and per-vector
// enables, reached over a classic wishbone slave.
// assumes one 50 MHz clock; event and destination inputs come
// from logic on the same clock; the core answers o_irq_valid
// with a one-cycle i_irq_accept.
//
// Operation
// - masked error entry raises no interrupt
// - error pending bit shows unaccepted interrupt
// - error message kind reads back zero
// - error vector is the one delivered
// - initial count copied on load and reload
// - current count read-only, shows live counter
// - divider from bit 3 and bits 1:0
// - capability reports four extra entries
// - capability bit 2 wide identifier reads one
// - capability bit 1 specific eoi reads one
// - capability bit 0 enable registers reads one
// - wide ids need all-ones broadcast destination
// - wide ids compare eight bits, else four
// - node settings also turn on wide ids
// - control bit 1 gates specific eoi messages
// - control bit 0 gates enable register writes
// - eoi write sends cycle for written vector
// - timer mode bit: one-shot or periodic
// - 256 enable bits, 32 per register
`timescale 1ns/1ps
`include "lapic_timer_ext_map.vh"

module local_interrupt_timer_ext_ctrl #(
  parameter ADDR_W = 12,
  parameter PRE_W = 7
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_b,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [ADDR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // interrupt sources and delivery to the core
  input wire i_error_event,
  input wire i_irq_accept,
  output reg o_irq_valid,
  output reg [7:0] o_irq_vector,
  // specific end-of-interrupt message
  output reg o_eoi_valid,
  output reg [7:0] o_eoi_vector,
  // destination matching
  input wire i_dest_valid,
  input wire [7:0] i_interrupt_destination,
  input wire [7:0] i_local_identifier,
  input wire i_node_wide_id_setting,
  input wire i_node_wide_broadcast_setting,
  output reg o_dest_match,
  output reg o_dest_broadcast,
  output reg o_wide_id_active
);

  // register state
  reg [7:0] err_vec_reg;
  reg err_mask_reg;
  reg [2:0] err_kind_reg;
  reg err_pend_reg;
  reg [7:0] tmr_vec_reg;
  reg tmr_mask_reg;
  reg tmr_mode_reg;
  reg [2:0] tmr_kind_reg;
  reg tmr_pend_reg;
  reg [31:0] init_cnt_reg;
  reg [31:0] cur_cnt_reg;
  reg [3:0] div_reg;
  reg [2:0] ctrl_reg;
  reg [7:0] eoi_vec_reg;
  reg [31:0] ier_mem [0:7];
  reg [PRE_W-1:0] pre_cnt_reg;
  reg irq_err_sel_reg;

  // byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[8*b +: 8] = dat[8*b +: 8];
        end
      end
    end
  endfunction

  // divide code to (ratio - 1) mask
  function [PRE_W-1:0] div_mask;
    input [3:0] code;
    begin
      case ({code[`BIT_DIV_HI], code[`DIV_LO_HI:0]})
        3'b000: div_mask = 7'h01;
        3'b001: div_mask = 7'h03;
        3'b010: div_mask = 7'h07;
        3'b011: div_mask = 7'h0F;
        3'b100: div_mask = 7'h1F;
        3'b101: div_mask = 7'h3F;
        3'b110: div_mask = 7'h7F;
        default: div_mask = 7'h00;
      endcase
    end
  endfunction

  // vector table entry read image
  function [31:0] entry_img;
    input mode;
    input mask;
    input pend;
    input [7:0] vec;
    begin
      entry_img = `RST_ZERO;
      entry_img[`BIT_MODE] = mode;
      entry_img[`BIT_MASK] = mask;
      entry_img[`BIT_PENDING] = pend;
      entry_img[`VEC_HI:`VEC_LO] = vec;
    end
  endfunction

  // bus decode
  wire req = i_wb_cyc & i_wb_stb;
  wire wr_now = req & i_wb_we & o_wb_ack;
  wire [ADDR_W-1:0] ofs = {i_wb_adr[ADDR_W-1:2], 2'b00};
  wire hit_ier = (ofs >= `OFS_ENABLE_BASE) && (ofs <= `OFS_ENABLE_LAST)
    && (ofs[3:2] == 2'b00);
  wire [2:0] ier_idx = ofs[6:4];
  wire [31:0] wdat_entry_t = merge(entry_img(tmr_mode_reg, tmr_mask_reg,
    1'b0, tmr_vec_reg) | {21'h0, tmr_kind_reg, 8'h00}, i_wb_dat, i_wb_sel);
  wire [31:0] wdat_entry_e = merge({15'h0, err_mask_reg, 5'h0, err_kind_reg,
    err_vec_reg}, i_wb_dat, i_wb_sel);
  wire [31:0] wdat_init = merge(init_cnt_reg, i_wb_dat, i_wb_sel);

  // read mux, unmapped words read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `RST_ZERO;
    case (ofs)
      `OFS_TIMER_ENTRY:
        rd_mux = entry_img(tmr_mode_reg, tmr_mask_reg, tmr_pend_reg,
          tmr_vec_reg);
      `OFS_ERROR_ENTRY:
        rd_mux = entry_img(1'b0, err_mask_reg, err_pend_reg,
          err_vec_reg);
      `OFS_INIT_COUNT: rd_mux = init_cnt_reg;
      `OFS_CUR_COUNT: rd_mux = cur_cnt_reg;
      `OFS_DIV_CONFIG: rd_mux = {28'h0, div_reg[3], 1'b0, div_reg[1:0]};
      `OFS_FEATURE_CAPS: begin
        rd_mux[`CAP_COUNT_LO +: 8] = `CAP_EXTRA_ENTRIES;
        rd_mux[`BIT_CAP_WIDE_ID] = 1'b1;
        rd_mux[`BIT_CAP_SEOI] = 1'b1;
        rd_mux[`BIT_CAP_IER] = 1'b1;
      end
      `OFS_EXT_CONTROL: rd_mux = {29'h0, ctrl_reg};
      `OFS_SPEC_EOI: rd_mux = {24'h0, eoi_vec_reg};
      default: begin
        if (hit_ier) begin
          rd_mux = ier_mem[ier_idx];
        end
      end
    endcase
  end

  // ack one cycle after request, dropped the cycle after
  // read data loaded only on the taken edge, so it
  // stands unchanged through the whole ack cycle
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `RST_ZERO;
    end else begin
      o_wb_ack <= req & ~o_wb_ack;
      if (req & ~o_wb_ack) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  // configuration registers written at the ack edge
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      err_vec_reg <= 8'h00;
      err_mask_reg <= 1'b1;
      err_kind_reg <= 3'h0;
      tmr_vec_reg <= 8'h00;
      tmr_mask_reg <= 1'b1;
      tmr_mode_reg <= 1'b0;
      tmr_kind_reg <= 3'h0;
      init_cnt_reg <= `RST_ZERO;
      div_reg <= 4'h0;
      ctrl_reg <= 3'h0;
      eoi_vec_reg <= 8'h00;
    end else if (wr_now) begin
      case (ofs)
        `OFS_TIMER_ENTRY: begin
          tmr_mode_reg <= wdat_entry_t[`BIT_MODE];
          tmr_mask_reg <= wdat_entry_t[`BIT_MASK];
          tmr_kind_reg <= wdat_entry_t[`KIND_HI:`KIND_LO];
          tmr_vec_reg <= wdat_entry_t[`VEC_HI:`VEC_LO];
        end
        `OFS_ERROR_ENTRY: begin
          err_mask_reg <= wdat_entry_e[`BIT_MASK];
          err_kind_reg <= wdat_entry_e[`KIND_HI:`KIND_LO];
          err_vec_reg <= wdat_entry_e[`VEC_HI:`VEC_LO];
        end
        `OFS_INIT_COUNT: init_cnt_reg <= wdat_init;
        `OFS_DIV_CONFIG: begin
          if (i_wb_sel[0]) begin
            div_reg <= {i_wb_dat[3], 1'b0, i_wb_dat[1:0]};
          end
        end
        `OFS_EXT_CONTROL: begin
          if (i_wb_sel[0]) begin
            ctrl_reg <= i_wb_dat[2:0];
          end
        end
        `OFS_SPEC_EOI: begin
          if (i_wb_sel[0]) begin
            eoi_vec_reg <= i_wb_dat[7:0];
          end
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // per-vector enable words, writes gated by control bit 0
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ier
      always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          ier_mem[g] <= `RST_ENABLE;
        end else if (wr_now && hit_ier && ier_idx == g
            && ctrl_reg[`BIT_IER_WR_EN]) begin
          ier_mem[g] <= merge(ier_mem[g], i_wb_dat, i_wb_sel);
        end
      end
    end
  endgenerate

  // specific eoi message, one pulse per enabled write
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_eoi_valid <= 1'b0;
      o_eoi_vector <= 8'h00;
    end else begin
      o_eoi_valid <= wr_now && ofs == `OFS_SPEC_EOI && i_wb_sel[0]
        && ctrl_reg[`BIT_SEOI_EN];
      if (wr_now && ofs == `OFS_SPEC_EOI && i_wb_sel[0]) begin
        o_eoi_vector <= i_wb_dat[7:0];
      end
    end
  end

  // prescaler, tick when masked count is all ones
  // never realigned by a load, so the first decrement
  // after a load may come up to one period early
  wire [PRE_W-1:0] dmask = div_mask(div_reg);
  wire tick = ((pre_cnt_reg & dmask) == dmask);
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pre_cnt_reg <= {PRE_W{1'b0}};
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  // timer counter
  // a load in the same cycle as a tick wins, so a fresh
  // count never fires on the cycle it is written
  wire init_wr = wr_now && ofs == `OFS_INIT_COUNT;
  wire tmr_fire = ~init_wr & tick & (cur_cnt_reg == 32'h0000_0001);
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cur_cnt_reg <= `RST_ZERO;
    end else if (init_wr) begin
      cur_cnt_reg <= wdat_init;
    end else if (tick && cur_cnt_reg != `RST_ZERO) begin
      if (tmr_fire && tmr_mode_reg) begin
        cur_cnt_reg <= init_cnt_reg;
      end else begin
        cur_cnt_reg <= cur_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // delivery: error first, vector must be enabled
  wire err_ok = ier_mem[err_vec_reg[7:5]][err_vec_reg[4:0]];
  wire tmr_ok = ier_mem[tmr_vec_reg[7:5]][tmr_vec_reg[4:0]];
  wire taken = o_irq_valid & i_irq_accept;
  wire err_taken = taken & irq_err_sel_reg;
  wire tmr_taken = taken & ~irq_err_sel_reg;

  // pending flags, a new event wins over acceptance
  // so an event in the accept cycle is never lost
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      err_pend_reg <= 1'b0;
      tmr_pend_reg <= 1'b0;
    end else begin
      if (i_error_event && !err_mask_reg) begin
        err_pend_reg <= 1'b1;
      end else if (err_taken) begin
        err_pend_reg <= 1'b0;
      end
      if (tmr_fire && !tmr_mask_reg) begin
        tmr_pend_reg <= 1'b1;
      end else if (tmr_taken) begin
        tmr_pend_reg <= 1'b0;
      end
    end
  end

  // offer held until the core accepts
  // a disabled error vector stays pending and lets the
  // timer through instead of blocking delivery
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_irq_valid <= 1'b0;
      o_irq_vector <= 8'h00;
      irq_err_sel_reg <= 1'b0;
    end else if (!o_irq_valid || taken) begin
      if (err_pend_reg && !err_taken && err_ok && !err_mask_reg) begin
        o_irq_valid <= 1'b1;
        o_irq_vector <= err_vec_reg;
        irq_err_sel_reg <= 1'b1;
      end else if (tmr_pend_reg && !tmr_taken && tmr_ok) begin
        o_irq_valid <= 1'b1;
        o_irq_vector <= tmr_vec_reg;
        irq_err_sel_reg <= 1'b0;
      end else begin
        o_irq_valid <= 1'b0;
      end
    end
  end

  // destination match and broadcast
  // node settings widen ids only when both are set
  wire wide = ctrl_reg[`BIT_WIDE_ID]
    | (i_node_wide_id_setting & i_node_wide_broadcast_setting);
  wire bcast = wide ? (i_interrupt_destination == `BCAST_WIDE)
    : (i_interrupt_destination[3:0] == `BCAST_NARROW);
  wire match = wide ? (i_interrupt_destination == i_local_identifier)
    : (i_interrupt_destination[3:0] == i_local_identifier[3:0]);
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_dest_match <= 1'b0;
      o_dest_broadcast <= 1'b0;
      o_wide_id_active <= 1'b0;
    end else begin
      o_dest_match <= i_dest_valid & match;
      o_dest_broadcast <= i_dest_valid & bcast;
      o_wide_id_active <= wide;
    end
  end

endmodule

// ==== local_interrupt_timer_ext_ctrl_asserts.sv ====
// port assertions for the timer and extended control slice
// assumes one clock domain and an active-low synchronous reset
`timescale 1ns/1ps
module local_interrupt_timer_ext_ctrl_asserts #(
  parameter ADDR_W = 12,
  parameter PRE_W = 7
) (
  // clock, reset and bus
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic i_wb_cyc,
  input logic i_wb_stb,
  input logic i_wb_we,
  input logic o_wb_ack,
  // delivery
  input logic i_irq_accept,
  input logic o_irq_valid,
  input logic [7:0] o_irq_vector,
  input logic o_eoi_valid,
  // destination compare
  input logic i_dest_valid,
  input logic [7:0] i_interrupt_destination,
  input logic [7:0] i_local_identifier,
  input logic i_node_wide_id_setting,
  input logic i_node_wide_broadcast_setting,
  input logic o_dest_match,
  input logic o_dest_broadcast,
  input logic o_wide_id_active
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_irq_hold; o_irq_valid && !i_irq_accept |=> o_irq_valid && $stable(o_irq_vector);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("offer dropped early");
  property p_eoi_once; o_eoi_valid |=> !o_eoi_valid; endproperty
  a_eoi_once: assert property (p_eoi_once) else $error("eoi not a pulse");
  property p_eoi_cause; o_eoi_valid |-> $past(o_wb_ack && i_wb_we); endproperty
  a_eoi_cause: assert property (p_eoi_cause) else $error("eoi without write");
  property p_dest_eq;
    i_dest_valid && i_interrupt_destination == i_local_identifier |=> o_dest_match;
  endproperty
  a_dest_eq: assert property (p_dest_eq) else $error("equal ids not matched");
  property p_dest_ne;
    i_dest_valid && i_interrupt_destination[3:0] != i_local_identifier[3:0]
      && i_interrupt_destination[3:0] != 4'hF |=> !o_dest_match;
  endproperty
  a_dest_ne: assert property (p_dest_ne) else $error("false match");
  property p_bc_all; i_dest_valid && i_interrupt_destination == 8'hFF |=> o_dest_broadcast;
  endproperty
  a_bc_all: assert property (p_bc_all) else $error("all ones not broadcast");
  property p_bc_no;
    i_dest_valid && i_interrupt_destination[3:0] != 4'hF |=> !o_dest_broadcast;
  endproperty
  a_bc_no: assert property (p_bc_no) else $error("false broadcast");
  property p_node_wide;
    i_node_wide_id_setting && i_node_wide_broadcast_setting |=> o_wide_id_active;
  endproperty
  a_node_wide: assert property (p_node_wide) else $error("node setting ignored");
endmodule

// ==== core_accept_model.sv ====
// core stand-in that takes offered interrupts
// assumes the slice holds each offer until it is accepted
`timescale 1ns/1ps
module core_accept_model (
  // clock, reset and stall
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic i_hold,
  // offer and acceptance
  input logic i_irq_valid,
  output logic o_irq_accept = 1'b0
);
  // one-cycle accept, only while an offer stands and not stalled
  always @(posedge i_clk_sys) begin
    o_irq_accept <= i_rst_b && i_irq_valid && !o_irq_accept && !i_hold;
  end
endmodule

// ==== local_interrupt_timer_ext_ctrl_test.sv ====
// self-checking bench for the timer and extended control slice
// assumes a one-cycle wishbone answer and a slow or prompt core
`timescale 1ns/1ps
module local_interrupt_timer_ext_ctrl_test;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ev = 1'b0;
  logic hold = 1'b0, dv = 1'b0, nid = 1'b0, nbc = 1'b0, acc, ack, irq, eoi, dm, db, wide;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0] dst = 8'h00, lid = 8'h00, ivec, evec, eoi_last;
  int fail_count = 0, checks_done = 0, cycles = 0, eoi_n = 0, i, m;
  always #10 clk = ~clk;
  local_interrupt_timer_ext_ctrl u_dut (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_error_event(ev),
    .i_irq_accept(acc), .o_irq_valid(irq), .o_irq_vector(ivec), .o_eoi_valid(eoi),
    .o_eoi_vector(evec), .i_dest_valid(dv), .i_interrupt_destination(dst),
    .i_local_identifier(lid), .i_node_wide_id_setting(nid),
    .i_node_wide_broadcast_setting(nbc), .o_dest_match(dm), .o_dest_broadcast(db),
    .o_wide_id_active(wide));
  core_accept_model u_core (.i_clk_sys(clk), .i_rst_b(rst_b), .i_hold(hold),
    .i_irq_valid(irq), .o_irq_accept(acc));
  // count eoi pulses and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (eoi === 1'b1) begin
      eoi_n++;
      eoi_last = evec;
    end
    if (cycles == 20000) begin
      fail_count++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic fire;
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 12 && irq !== 1'b1; k++) @(negedge clk);
    chk(irq, 1'b1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, capability word, unmapped place
    rd(12'h370, 32'h0001_0000);
    rd(12'h380, 32'h0);
    rd(12'h3E0, 32'h0);
    rd(12'h410, 32'h0);
    rd(12'h420, 32'h0);
    rd(12'h5F0, 32'h0);
    wb(1'b1, 12'h390, 32'hFFFF_FFFF);
    wb(1'b1, 12'h400, 32'h0);
    rd(12'h390, 32'h0);
    rd(12'h400, 32'h0004_0007);
    // error entry: kind hidden, pending seen while the core stalls
    wb(1'b1, 12'h370, 32'h0000_0735);
    rd(12'h370, 32'h0000_0035);
    hold <= 1'b1;
    fire;
    wait_irq;
    chk(ivec, 8'h35);
    rd(12'h370, 32'h0000_1035);
    hold <= 1'b0;
    idle(4);
    rd(12'h370, 32'h0000_0035);
    // masked entry stays silent
    wb(1'b1, 12'h370, 32'h0001_0042);
    fire;
    idle(6);
    chk(irq, 1'b0);
    rd(12'h370, 32'h0001_0042);
    // enable registers gated, disabled vector waits
    wb(1'b1, 12'h480, 32'h0);
    rd(12'h480, 32'hFFFF_FFFF);
    wb(1'b1, 12'h410, 32'h0000_0003);
    wb(1'b1, 12'h4A0, 32'hFFFF_FFFB);
    rd(12'h4A0, 32'hFFFF_FFFB);
    wb(1'b1, 12'h370, 32'h0000_0042);
    fire;
    idle(6);
    chk(irq, 1'b0);
    rd(12'h370, 32'h0000_1042);
    wb(1'b1, 12'h4A0, 32'hFFFF_FFFF);
    wait_irq;
    chk(ivec, 8'h42);
    // specific eoi only while control bit 1 is set
    wb(1'b1, 12'h420, 32'h0000_0042);
    idle(3);
    chk(eoi_n, 1);
    chk(eoi_last, 8'h42);
    wb(1'b1, 12'h410, 32'h0000_0001);
    wb(1'b1, 12'h420, 32'h0000_005A);
    idle(3);
    chk(eoi_n, 1);
    // divide field codes
    for (i = 0; i < 16; i++) begin
      wb(1'b1, 12'h3E0, i);
      rd(12'h3E0, i & 32'hB);
    end
    // one-shot count to zero at divide by 1
    wb(1'b1, 12'h3E0, 32'h0000_000B);
    wb(1'b1, 12'h380, 32'h0000_000A);
    rd(12'h380, 32'h0000_000A);
    idle(12);
    rd(12'h390, 32'h0);
    // divide by 128 allows one tick at most
    wb(1'b1, 12'h3E0, 32'h0000_000A);
    wb(1'b1, 12'h380, 32'h0000_0002);
    idle(40);
    wb(1'b0, 12'h390, 32'h0);
    chk(q == 1 || q == 2, 1'b1);
    // periodic reloads, count never stops at zero
    wb(1'b1, 12'h3E0, 32'h0000_000B);
    wb(1'b1, 12'h320, 32'h0003_0000);
    wb(1'b1, 12'h380, 32'h0000_0005);
    idle(23);
    wb(1'b0, 12'h390, 32'h0);
    chk(q >= 1 && q <= 5, 1'b1);
    // unmasked one-shot fires, then zero load stays quiet
    wb(1'b1, 12'h380, 32'h0);
    wb(1'b1, 12'h320, 32'h0000_0051);
    hold <= 1'b1;
    wb(1'b1, 12'h380, 32'h0000_0003);
    wait_irq;
    chk(ivec, 8'h51);
    @(posedge clk);
    hold <= 1'b0;
    wb(1'b1, 12'h380, 32'h0);
    idle(10);
    chk(irq, 1'b0);
    rd(12'h390, 32'h0);
    // destination compare: narrow, control bit 2, node settings
    lid <= 8'h33;
    for (m = 0; m < 3; m++) begin
      wb(1'b1, 12'h410, (m == 1) ? 32'h5 : 32'h1);
      nid <= (m == 2);
      nbc <= (m == 2);
      for (i = 0; i < 17; i++) begin
        @(posedge clk);
        dv <= 1'b1;
        dst <= (i == 16) ? 8'h73 : i[3:0] * 8'h11;
      end
      idle(2);
      chk(dm, m == 0);
      chk(wide, m != 0);
      dst <= 8'h3F;
      idle(2);
      chk(db, m == 0);
      dv <= 1'b0;
    end
    test_done;
  end
endmodule
bind local_interrupt_timer_ext_ctrl local_interrupt_timer_ext_ctrl_asserts #(
  .ADDR_W(ADDR_W), .PRE_W(PRE_W)) u_chk (.i_clk_sys, .i_rst_b, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .o_wb_ack, .i_irq_accept, .o_irq_valid, .o_irq_vector, .o_eoi_valid,
  .i_dest_valid, .i_interrupt_destination, .i_local_identifier, .i_node_wide_id_setting,
  .i_node_wide_broadcast_setting, .o_dest_match, .o_dest_broadcast, .o_wide_id_active);
